// ---- imr_baud_gen.sv ----
// baud rate generator: reloadable down counter that marks one baud period
`include "imr_regs.svh"
`default_nettype none
module imr_baud_gen (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire imr_pkg::imr_byte_t reload_value,
  input wire logic run,
  output logic expired
);
  import imr_pkg::*;

  imr_byte_t cnt_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `IMR_BRG_ZERO;
    end else if (load) begin
      cnt_q <= reload_value;
    end else if (run && (cnt_q != `IMR_BRG_ZERO)) begin
      cnt_q <= cnt_q - `IMR_BRG_STEP;
    end
  end

  // expiry must not depend on load: callers reload on expiry, which would close a loop
  assign expired = run && (cnt_q == `IMR_BRG_ZERO);

endmodule : imr_baud_gen
`default_nettype wire

// ---- imr_i2c_master.sv ----
// i2c master sequencer: repeated start generation and byte transmission with ack capture
//
// Contract
// - a restart begins only when requested while the sequencer is idle
// - a restart request made while any other event runs is ignored
// - restart pulls scl low, then on scl low loads baud and releases sda
// - after that period with sda high, release scl; on scl high reload baud
// - then drive sda low one baud period with scl high, then pull scl low
// - restart end clears the request, no baud reload, sda stays low
// - start-seen flag sets as soon as a start appears on the lines
// - port event flag for a restart waits for the baud timeout
// - collision if sda is low when scl rises during a restart
// - collision if scl falls before sda is driven low during a restart
// - buffer write sets buffer-full and starts the baud generator
// - each bit goes onto sda after scl falls; scl low one baud period
// - released scl is held high one baud period with sda stable
// - address byte is seven address bits then read/write, msb first
// - at the eighth falling edge clear buffer-full and release sda
// - ack status clears on low acknowledge and sets on no acknowledge
// - after the ninth clock set port event, suspend baud, hold scl low
// - a write while busy sets write collision and leaves the buffer unchanged
// - after a start completes, wait the start time before further operations
// - software ends with stop or restart; event flag raised on completion
// - every baud reload takes the low eight bits of the reload value
// - baud generator pauses after scl release until scl is sampled high
`include "imr_regs.svh"
`default_nettype none
module imr_i2c_master (
  input wire logic sys_clk,
  input wire logic rst,
  input wire imr_pkg::imr_byte_t baud_reload_value,
  input wire logic restart_request_set,
  output logic restart_request,
  input wire logic buf_wr,
  input wire imr_pkg::imr_byte_t buf_wr_data,
  output imr_pkg::imr_byte_t transfer_buffer,
  output logic buffer_full_flag,
  output logic write_collision_flag,
  input wire logic write_collision_clr,
  output logic ack_status_flag,
  output logic port_event_flag,
  input wire logic port_event_clr,
  output logic start_seen_flag,
  input wire logic start_seen_clr,
  output logic bus_collision_flag,
  input wire logic bus_collision_clr,
  output logic busy,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import imr_pkg::*;

  // an open-drain line is pulled low for a zero and released for a one
  function automatic logic pull_for(input logic level);
    pull_for = !level;
  endfunction : pull_for

  imr_state_t state_q;
  imr_byte_t bit_shift_register_q;
  imr_byte_t transfer_buffer_q;
  imr_byte_t hold_q;
  logic [3:0] bit_cnt_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic restart_request_q;
  logic buffer_full_q;
  logic write_collision_q;
  logic ack_status_q;
  logic port_event_q;
  logic start_seen_q;
  logic bus_collision_q;

  logic is_idle;
  logic rs_accept;
  logic wr_accept;
  logic brg_load;
  logic brg_run;
  logic brg_exp;
  logic rs_done;
  logic rs_abort;
  logic byte_done;
  logic ack_sample;
  logic bf_clear;
  logic start_pulse;

  imr_baud_gen u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(brg_load),
    .reload_value(baud_reload_value),
    .run(brg_run),
    .expired(brg_exp)
  );

  imr_start_det u_start (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .start_pulse(start_pulse)
  );

  assign is_idle = (state_q == IMR_ST_IDLE);
  // a restart and a buffer write in the same cycle: the restart wins, the write collides
  assign rs_accept = restart_request_set && is_idle;
  assign wr_accept = buf_wr && is_idle && !restart_request_set;

  always_comb begin
    brg_load = 1'b0;
    brg_run = 1'b0;
    rs_done = 1'b0;
    rs_abort = 1'b0;
    byte_done = 1'b0;
    ack_sample = 1'b0;
    bf_clear = 1'b0;
    case (state_q)
      IMR_ST_IDLE: begin
        brg_load = wr_accept;
      end
      IMR_ST_RS_SCL_LOW: begin
        brg_load = !scl_i;
      end
      IMR_ST_RS_SDA_HI: begin
        brg_run = 1'b1;
      end
      IMR_ST_RS_SCL_RISE: begin
        // counting stays paused while a slave stretches the clock
        brg_load = scl_i && sda_i;
        rs_abort = scl_i && !sda_i;
      end
      IMR_ST_RS_BOTH_HI: begin
        brg_run = 1'b1;
        rs_abort = !scl_i;
        brg_load = scl_i && brg_exp;
      end
      IMR_ST_RS_SDA_LOW: begin
        brg_run = 1'b1;
        rs_done = brg_exp;
      end
      IMR_ST_TX_LOW: begin
        brg_run = 1'b1;
      end
      IMR_ST_TX_RISE: begin
        brg_load = scl_i;
        ack_sample = scl_i && (bit_cnt_q == `IMR_BIT_CNT_ACK);
      end
      IMR_ST_TX_HIGH: begin
        brg_run = 1'b1;
        brg_load = brg_exp && (bit_cnt_q != `IMR_BIT_CNT_ACK);
        byte_done = brg_exp && (bit_cnt_q == `IMR_BIT_CNT_ACK);
        bf_clear = brg_exp && (bit_cnt_q == `IMR_BIT_CNT_LAST);
      end
      default: begin
        brg_run = 1'b0;
      end
    endcase
  end

  // sequencer: state, line pulls, shift register and bit count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= IMR_ST_IDLE;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      bit_shift_register_q <= `IMR_BYTE_ZERO;
      bit_cnt_q <= `IMR_BIT_CNT_ZERO;
      hold_q <= `IMR_HOLD_ZERO;
    end else begin
      case (state_q)
        IMR_ST_IDLE: begin
          if (rs_accept) begin
            scl_oe_q <= 1'b1;
            state_q <= IMR_ST_RS_SCL_LOW;
          end else if (wr_accept) begin
            // scl is pulled low here, so the first bit goes out at once
            bit_shift_register_q <= buf_wr_data;
            bit_cnt_q <= `IMR_BIT_CNT_ZERO;
            scl_oe_q <= 1'b1;
            sda_oe_q <= pull_for(buf_wr_data[`IMR_SR_MSB]);
            state_q <= IMR_ST_TX_LOW;
          end
        end
        IMR_ST_HOLD: begin
          if (hold_q == `IMR_HOLD_ZERO) begin
            state_q <= IMR_ST_IDLE;
          end else begin
            hold_q <= hold_q - `IMR_HOLD_STEP;
          end
        end
        IMR_ST_RS_SCL_LOW: begin
          if (!scl_i) begin
            sda_oe_q <= 1'b0;
            state_q <= IMR_ST_RS_SDA_HI;
          end
        end
        IMR_ST_RS_SDA_HI: begin
          // a low sda keeps scl held; no collision is defined at this point
          if (brg_exp && sda_i) begin
            scl_oe_q <= 1'b0;
            state_q <= IMR_ST_RS_SCL_RISE;
          end
        end
        IMR_ST_RS_SCL_RISE: begin
          if (rs_abort) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            state_q <= IMR_ST_IDLE;
          end else if (scl_i) begin
            state_q <= IMR_ST_RS_BOTH_HI;
          end
        end
        IMR_ST_RS_BOTH_HI: begin
          if (rs_abort) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            state_q <= IMR_ST_IDLE;
          end else if (brg_exp) begin
            sda_oe_q <= 1'b1;
            state_q <= IMR_ST_RS_SDA_LOW;
          end
        end
        IMR_ST_RS_SDA_LOW: begin
          if (brg_exp) begin
            scl_oe_q <= 1'b1;
            hold_q <= `IMR_HOLD_LOAD;
            state_q <= IMR_ST_HOLD;
          end
        end
        IMR_ST_TX_LOW: begin
          if (brg_exp) begin
            scl_oe_q <= 1'b0;
            state_q <= IMR_ST_TX_RISE;
          end
        end
        IMR_ST_TX_RISE: begin
          if (scl_i) begin
            state_q <= IMR_ST_TX_HIGH;
          end
        end
        IMR_ST_TX_HIGH: begin
          if (brg_exp) begin
            scl_oe_q <= 1'b1;
            if (bit_cnt_q == `IMR_BIT_CNT_ACK) begin
              state_q <= IMR_ST_IDLE;
            end else if (bit_cnt_q == `IMR_BIT_CNT_LAST) begin
              sda_oe_q <= 1'b0;
              bit_cnt_q <= bit_cnt_q + `IMR_BIT_CNT_STEP;
              state_q <= IMR_ST_TX_LOW;
            end else begin
              bit_shift_register_q <= {bit_shift_register_q[`IMR_SR_MSB - 1:0], 1'b0};
              sda_oe_q <= pull_for(bit_shift_register_q[`IMR_SR_MSB - 1]);
              bit_cnt_q <= bit_cnt_q + `IMR_BIT_CNT_STEP;
              state_q <= IMR_ST_TX_LOW;
            end
          end
        end
        default: begin
          state_q <= IMR_ST_IDLE;
        end
      endcase
    end
  end

  // restart request bit: only taken while idle, cleared by hardware at the end or on a bus collision
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      restart_request_q <= 1'b0;
    end else if (rs_accept) begin
      restart_request_q <= 1'b1;
    end else if (rs_done || rs_abort) begin
      restart_request_q <= 1'b0;
    end
  end

  // transfer buffer keeps its old contents on a refused write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transfer_buffer_q <= `IMR_BYTE_ZERO;
    end else if (wr_accept) begin
      transfer_buffer_q <= buf_wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buffer_full_q <= 1'b0;
    end else if (wr_accept) begin
      buffer_full_q <= 1'b1;
    end else if (bf_clear) begin
      buffer_full_q <= 1'b0;
    end
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      write_collision_q <= 1'b0;
    end else if (buf_wr && !wr_accept) begin
      write_collision_q <= 1'b1;
    end else if (write_collision_clr) begin
      write_collision_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_status_q <= 1'b0;
    end else if (ack_sample) begin
      ack_status_q <= sda_i;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port_event_q <= 1'b0;
    end else if (rs_done || byte_done) begin
      port_event_q <= 1'b1;
    end else if (port_event_clr) begin
      port_event_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_seen_q <= 1'b0;
    end else if (start_pulse) begin
      start_seen_q <= 1'b1;
    end else if (start_seen_clr) begin
      start_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_collision_q <= 1'b0;
    end else if (rs_abort) begin
      bus_collision_q <= 1'b1;
    end else if (bus_collision_clr) begin
      bus_collision_q <= 1'b0;
    end
  end

  assign restart_request = restart_request_q;
  assign transfer_buffer = transfer_buffer_q;
  assign buffer_full_flag = buffer_full_q;
  assign write_collision_flag = write_collision_q;
  assign ack_status_flag = ack_status_q;
  assign port_event_flag = port_event_q;
  assign start_seen_flag = start_seen_q;
  assign bus_collision_flag = bus_collision_q;
  assign busy = !is_idle;
  // pads only ever pull low; a released line floats high on the pull-up
  assign scl_o = `IMR_LINE_LOW;
  assign sda_o = `IMR_LINE_LOW;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;

endmodule : imr_i2c_master
`default_nettype wire

// ---- imr_i2c_master_sva.sv ----
// concurrent checks on the ports of the i2c master sequencer
`default_nettype none
module imr_i2c_master_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire imr_pkg::imr_byte_t baud_reload_value,
  input wire logic restart_request_set,
  input wire logic restart_request,
  input wire logic buf_wr,
  input wire imr_pkg::imr_byte_t buf_wr_data,
  input wire imr_pkg::imr_byte_t transfer_buffer,
  input wire logic buffer_full_flag,
  input wire logic write_collision_flag,
  input wire logic port_event_flag,
  input wire logic bus_collision_flag,
  input wire logic busy,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  import imr_pkg::*;
  logic [8:0] lo_q;
  // saturating so a long idle hold cannot wrap into a short count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) lo_q <= 9'h000;
    else if (!scl_oe) lo_q <= 9'h000;
    else if (lo_q != 9'h1ff) lo_q <= lo_q + 9'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence wr_ok;
    buf_wr && !busy && !restart_request_set;
  endsequence
  sequence wr_busy;
    buf_wr && busy && !restart_request_set;
  endsequence
  sequence rs_done;
    $fell(restart_request) && !bus_collision_flag;
  endsequence
  open_drain_a: assert property (!scl_o && !sda_o) else $error("line driven high");
  write_accept_a: assert property (wr_ok |=> buffer_full_flag && scl_oe
    && transfer_buffer == $past(buf_wr_data)) else $error("write not taken");
  write_refuse_a: assert property (wr_busy |=> write_collision_flag
    && $stable(transfer_buffer)) else $error("busy write not refused");
  restart_take_a: assert property (restart_request_set && !busy |=> restart_request && scl_oe)
    else $error("restart not taken");
  restart_end_a: assert property (rs_done |-> port_event_flag && scl_oe && sda_oe)
    else $error("restart end wrong");
  start_hold_a: assert property (rs_done |-> ##39 busy) else $error("start hold short");
  stretch_wait_a: assert property (busy && !scl_oe && !scl_i |=> !scl_oe)
    else $error("stretch not honoured");
  low_time_a: assert property ($fell(scl_oe) |-> lo_q >= {1'h0, baud_reload_value})
    else $error("scl low too short");
  sda_stable_a: assert property (busy && !restart_request && !scl_oe && $past(!scl_oe)
    && $past(scl_i) |-> $stable(sda_oe)) else $error("sda moved with scl high");
  bf_clear_a: assert property ($fell(buffer_full_flag) |-> !sda_oe) else $error("sda held for ack");
  idle_hold_a: assert property (!busy && scl_oe && !buf_wr && !restart_request_set |=> scl_oe)
    else $error("scl let go while idle");
endmodule : imr_i2c_master_sva
`default_nettype wire

// ---- imr_pkg.sv ----
// types shared by the i2c master restart and transmit sequencer
`default_nettype none
package imr_pkg;

  typedef logic [7:0] imr_byte_t;

  typedef enum logic [9:0] {
    IMR_ST_IDLE        = 10'b00_0000_0001,
    IMR_ST_HOLD        = 10'b00_0000_0010,
    IMR_ST_RS_SCL_LOW  = 10'b00_0000_0100,
    IMR_ST_RS_SDA_HI   = 10'b00_0000_1000,
    IMR_ST_RS_SCL_RISE = 10'b00_0001_0000,
    IMR_ST_RS_BOTH_HI  = 10'b00_0010_0000,
    IMR_ST_RS_SDA_LOW  = 10'b00_0100_0000,
    IMR_ST_TX_LOW      = 10'b00_1000_0000,
    IMR_ST_TX_RISE     = 10'b01_0000_0000,
    IMR_ST_TX_HIGH     = 10'b10_0000_0000
  } imr_state_t;

endpackage : imr_pkg
`default_nettype wire

// ---- imr_regs.svh ----
// constants for the i2c master restart and transmit sequencer
`ifndef IMR_REGS_SVH
`define IMR_REGS_SVH

// system clock period and the settle time after a restart completes
`define IMR_CLK_PERIOD_NS 25
`define IMR_START_HOLD_NS 1000
`define IMR_START_HOLD_CYC ((`IMR_START_HOLD_NS + `IMR_CLK_PERIOD_NS - 1) / `IMR_CLK_PERIOD_NS)
`define IMR_HOLD_LOAD 8'(`IMR_START_HOLD_CYC)
`define IMR_HOLD_ZERO 8'h00
`define IMR_HOLD_STEP 8'h01

// baud generator
`define IMR_BRG_ZERO 8'h00
`define IMR_BRG_STEP 8'h01

// bit sequencing within one byte: bits 0..7 are data, 8 is the acknowledge slot
`define IMR_BIT_CNT_ZERO 4'h0
`define IMR_BIT_CNT_STEP 4'h1
`define IMR_BIT_CNT_LAST 4'h7
`define IMR_BIT_CNT_ACK 4'h8
`define IMR_SR_MSB 7
`define IMR_BYTE_ZERO 8'h00

// open-drain lines only ever pull low
`define IMR_LINE_LOW 1'b0

`endif

// ---- imr_slave_model.sv ----
// behavioural i2c slave: wired lines, byte capture, acknowledge and clock stretching
`default_nettype none
module imr_slave_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic nack,
  input wire logic stretch,
  input wire logic grab,
  output logic scl_line,
  output logic sda_line,
  output imr_pkg::imr_byte_t rx_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import imr_pkg::*;
  logic scl_p_q, sda_p_q, ack_q, hold_q;
  logic [3:0] bit_q;
  logic [2:0] st_q;
  // pull-ups: a released line reads high
  assign scl_line = ~(scl_oe | hold_q);
  assign sda_line = ~(sda_oe | ack_q);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // line history starts at the idle high level so reset shows no false edge
      {scl_p_q, sda_p_q, ack_q, hold_q} <= 4'hc;
      bit_q <= 4'h0;
      st_q <= 3'h0;
      rx_q <= 8'h00;
    end else begin
      scl_p_q <= scl_line;
      sda_p_q <= sda_line;
      if (scl_line && !scl_p_q) begin
        if (bit_q < 4'h8) rx_q <= {rx_q[6:0], sda_line};
        bit_q <= bit_q + 4'h1;
      end
      if (!scl_line && scl_p_q) begin
        ack_q <= (bit_q == 4'h8) && !nack;
        if (bit_q == 4'h9) bit_q <= 4'h0;
      end
      // grab pulls scl low mid-high to provoke a collision
      if ((!scl_line && scl_p_q && stretch) || (grab && scl_line && scl_p_q)) begin
        hold_q <= 1'h1;
        st_q <= 3'h7;
      end else if (hold_q) begin
        st_q <= st_q - 3'h1;
        if (st_q == 3'h0) hold_q <= 1'h0;
      end
      if (scl_line && scl_p_q && !sda_line && sda_p_q) bit_q <= 4'h0;
    end
  end
endmodule : imr_slave_model
`default_nettype wire

// ---- imr_start_det.sv ----
// start condition detector: sda falling while scl is high
`include "imr_regs.svh"
`default_nettype none
module imr_start_det (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic start_pulse
);
  import imr_pkg::*;

  logic sda_prev_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sda_prev_q <= 1'b1;
    end else begin
      sda_prev_q <= sda_i;
    end
  end

  assign start_pulse = scl_i && sda_prev_q && !sda_i;

endmodule : imr_start_det
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the i2c master sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import imr_pkg::*;
  logic sys_clk = 0, rst = 1, restart_request_set = 0, buf_wr = 0, write_collision_clr = 0;
  logic port_event_clr = 0, start_seen_clr = 0, bus_collision_clr = 0, nack = 0, stretch = 0, grab = 0;
  logic restart_request, buffer_full_flag, write_collision_flag, ack_status_flag, port_event_flag;
  logic start_seen_flag, bus_collision_flag, busy, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  imr_byte_t baud_reload_value = 8'h03, buf_wr_data = 8'h00, transfer_buffer, rx_q;
  imr_byte_t tx [2] = '{8'ha4, 8'h5b};
  int n_fail = 0, checked = 0;
  always #12.5 sys_clk = ~sys_clk;
  imr_i2c_master dut (.sys_clk, .rst, .baud_reload_value, .restart_request_set, .restart_request,
    .buf_wr, .buf_wr_data, .transfer_buffer, .buffer_full_flag, .write_collision_flag,
    .write_collision_clr, .ack_status_flag, .port_event_flag, .port_event_clr, .start_seen_flag,
    .start_seen_clr, .bus_collision_flag, .bus_collision_clr, .busy, .scl_i, .scl_o, .scl_oe,
    .sda_i, .sda_o, .sda_oe);
  imr_slave_model slave (.sys_clk, .rst, .scl_oe, .sda_oe, .nack, .stretch, .grab,
    .scl_line(scl_i), .sda_line(sda_i), .rx_q);
  task automatic chk(input imr_byte_t got, input imr_byte_t exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic rs;
    @(posedge sys_clk) restart_request_set <= 1'h1;
    @(posedge sys_clk) restart_request_set <= 1'h0;
    #1;
  endtask : rs
  task automatic wr(input imr_byte_t b);
    @(posedge sys_clk) buf_wr <= 1'h1;
    buf_wr_data <= b;
    @(posedge sys_clk) buf_wr <= 1'h0;
    #1;
  endtask : wr
  task automatic clr;
    @(posedge sys_clk) {port_event_clr, write_collision_clr, start_seen_clr, bus_collision_clr} <= 4'hf;
    @(posedge sys_clk) {port_event_clr, write_collision_clr, start_seen_clr, bus_collision_clr} <= 4'h0;
    #1;
  endtask : clr
  // bounded wait: 0 port event, 1 idle, 2 bus collision
  task automatic wt(input int k);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge sys_clk) #1;
      if ((k == 0 && port_event_flag === 1'h1) || (k == 1 && busy === 1'h0)
        || (k == 2 && bus_collision_flag === 1'h1)) break;
    end
    if (n == 3000) begin
      n_fail++;
      give_verdict;
    end
  endtask : wt
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk({7'h00, busy}, 8'h00);
    chk(transfer_buffer, 8'h00);
    rs;
    chk({7'h00, restart_request}, 8'h01);
    wt(0);
    chk({7'h00, restart_request}, 8'h00);
    chk({7'h00, sda_oe}, 8'h01);
    chk({7'h00, start_seen_flag}, 8'h01);
    rs;
    chk({7'h00, restart_request}, 8'h00);
    wr(8'h11);
    chk({7'h00, write_collision_flag}, 8'h01);
    chk(transfer_buffer, 8'h00);
    chk({7'h00, busy}, 8'h01);
    clr;
    chk({7'h00, write_collision_flag}, 8'h00);
    wt(1);
    for (int i = 0; i < 2; i++) begin
      nack <= i[0];
      stretch <= i[0];
      wr(tx[i]);
      chk({7'h00, buffer_full_flag}, 8'h01);
      chk(transfer_buffer, tx[i]);
      wt(0);
      chk(rx_q, tx[i]);
      chk({7'h00, ack_status_flag}, {7'h00, i[0]});
      chk({7'h00, buffer_full_flag}, 8'h00);
      chk({7'h00, scl_oe}, 8'h01);
      clr;
    end
    grab <= 1'h1;
    rs;
    wt(2);
    chk({7'h00, restart_request}, 8'h00);
    chk({7'h00, bus_collision_flag}, 8'h01);
    clr;
    chk({7'h00, bus_collision_flag}, 8'h00);
    chk({7'h00, start_seen_flag}, 8'h00);
    give_verdict;
  end
endmodule : testbench
bind imr_i2c_master imr_i2c_master_sva u_sva (.sys_clk, .rst, .baud_reload_value, .restart_request_set,
  .restart_request, .buf_wr, .buf_wr_data, .transfer_buffer, .buffer_full_flag, .write_collision_flag,
  .port_event_flag, .bus_collision_flag, .busy, .scl_i, .scl_o, .scl_oe, .sda_o, .sda_oe);
`default_nettype wire
